// file: pkg/crc_unit_defs.vh
/*
 * Register offsets, field positions, reset values and codes for the CRC checksum unit.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CRC_UNIT_DEFS_VH
`define CRC_UNIT_DEFS_VH

// ==================================================================
// Register indices (byte address is four times the index)
`define IDX_CONTROL     3'h0
`define IDX_FLAGS       3'h1
`define IDX_RESERVED    3'h2
`define IDX_BYTE_INPUT  3'h3
`define IDX_RESULT0     3'h4
`define IDX_RESULT1     3'h5
`define IDX_RESULT2     3'h6
`define IDX_RESULT3     3'h7
`define IDX_IRQ_STATUS  4'h8
`define IDX_IRQ_MASK    4'h9
`define IDX_FEED        4'ha

// ==================================================================
// Control fields
`define CTL_PRESET_HI   7
`define CTL_PRESET_LO   6
`define CTL_WIDE        5
`define CTL_SRC_HI      3
`define CTL_SRC_LO      0

// ==================================================================
// Source codes
`define SRC_DISABLED    4'h0
`define SRC_PROCESSOR   4'h1
`define SRC_FLASH       4'h2
`define SRC_DMA0        4'h4
`define SRC_DMA3        4'h7

// ==================================================================
// Flag bits and values
`define FLG_BUSY        0
`define FLG_ZERO        1
`define PRESET_ZEROS    2'h2
`define PRESET_ONES     2'h3
`define POLY_NARROW     16'h1021
`define POLY_WIDE       32'h04c11db7
`define CTL_RESET       8'h00
`define CRC_RESET       32'h00000000

// ==================================================================
// Interrupt bits: 0 calculation done, 1 zero result
`define IRQ_DONE        0
`define IRQ_ZERO        1

`endif

// file: logic/crc_byte_step.v
/*
 * One byte folded into a CRC state, MSB first, in one cycle of logic.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
`include "crc_unit_defs.vh"

module crc_byte_step (
	input  wire [31:0] state_i,
	input  wire [7:0]  data_i,
	input  wire        wide_i,
	output reg  [31:0] state_o
);
	integer k;
	reg     fb;

	always @* begin
		state_o = state_i;
		fb = 1'b0;
		for (k = 7; k >= 0; k = k - 1) begin
			if (wide_i) begin
				fb = state_o[31] ^ data_i[k];
				state_o = {state_o[30:0], 1'b0} ^ (fb ? `POLY_WIDE : 32'h00000000);
			end else begin
				fb = state_o[15] ^ data_i[k];
				state_o = {16'h0000, state_o[14:0], 1'b0} ^
					(fb ? {16'h0000, `POLY_NARROW} : 32'h00000000);
			end
		end
	end
endmodule // crc_byte_step

// file: logic/crc_irq_bit.v
/*
 * One sticky interrupt status bit: set by an event, cleared by a status read.
 * Assumes the set and the clear are single-cycle pulses.
 */
`timescale 1ns/1ps

module crc_irq_bit (
	input  wire sys_clk_i,
	input  wire reset_i,
	input  wire enable_i,
	input  wire set_i,
	input  wire clear_i,
	output reg  flag_o
);
	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			flag_o <= 1'b0;
		end else if (enable_i) begin
			// A set in the clearing cycle wins.
			if (set_i)
				flag_o <= 1'b1;
			else if (clear_i)
				flag_o <= 1'b0;
		end
	end
endmodule // crc_irq_bit

// file: logic/crc_checksum_unit.v
/*
 * CRC checksum unit with an AHB-Lite register slave and a level interrupt.
 * Assumes one clock, synchronous reset, single word transfers, and that the DMA
 * and flash scan sources present bytes on the feed port with a done strobe.
 */
`timescale 1ns/1ps
`include "crc_unit_defs.vh"

module crc_checksum_unit (
	input  wire        sys_clk_i,
	input  wire        reset_i,
	input  wire        clk_en_i,
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output wire [31:0] hrdata_o,
	output wire        hreadyout_o,
	output wire        hresp_o,
	input  wire        feed_valid_i,
	input  wire [7:0]  feed_data_i,
	input  wire [1:0]  feed_channel_i,
	input  wire        feed_done_i,
	output wire        irq_o
);
	// ==================================================================
	// Bus address phase capture
	reg        wr_pend_reg;
	reg        rd_pend_reg;
	reg  [3:0] idx_reg;
	reg  [31:0] rdata_reg;
	wire       take;
	wire [3:0] a_idx;

	assign take        = hsel_i & hready_i & htrans_i[1] & clk_en_i;
	assign a_idx       = haddr_i[5:2];
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rdata_reg;

	// ==================================================================
	// Control state
	reg  [3:0]  source_reg;
	reg         wide_reg;
	reg         busy_reg;
	reg         zero_reg;
	reg  [1:0]  preset_reg;
	reg  [31:0] crc_reg;
	reg  [1:0]  irq_mask_reg;
	wire [31:0] step_out;
	wire [1:0]  irq_flags;
	wire        src_dma;
	wire        src_active;
	wire        ctl_write;
	wire        status_write;
	wire        in_write;
	wire        feed_take;
	wire        done_evt;
	wire [31:0] shown;
	wire [31:0] reversed;
	reg  [31:0] crc_next;
	reg  [7:0]  step_byte;
	reg         step_go;
	integer     i;

	assign src_dma    = (source_reg[3:2] == 2'b01);
	assign src_active = (source_reg != `SRC_DISABLED);
	assign ctl_write    = wr_pend_reg & clk_en_i & (idx_reg == {1'b0, `IDX_CONTROL});
	assign status_write = wr_pend_reg & clk_en_i & (idx_reg == {1'b0, `IDX_FLAGS});
	assign in_write = wr_pend_reg & clk_en_i & (idx_reg == {1'b0, `IDX_BYTE_INPUT});
	assign feed_take = feed_valid_i & clk_en_i & busy_reg &
		((src_dma & (feed_channel_i == source_reg[1:0])) |
		 (source_reg == `SRC_FLASH));

	// Busy clears on write-one for the processor source, on done for the others.
	assign done_evt = clk_en_i & busy_reg &
		((status_write & hwdata_i[`FLG_BUSY] & (source_reg == `SRC_PROCESSOR)) |
		 (feed_done_i & (src_dma | (source_reg == `SRC_FLASH))));

	always @* begin
		step_byte = feed_data_i;
		step_go   = feed_take;
		if (in_write & busy_reg & (source_reg == `SRC_PROCESSOR)) begin
			step_byte = hwdata_i[7:0];
			step_go   = 1'b1;
		end
	end

	crc_byte_step u_step (
		.state_i (crc_reg),
		.data_i  (step_byte),
		.wide_i  (wide_reg),
		.state_o (step_out)
	);

	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : g_rev
			assign reversed[g] = ~crc_reg[31 - g];
		end
	endgenerate

	assign shown = ((source_reg == `SRC_FLASH) & busy_reg) ? 32'h00000000 :
		(wide_reg & ~busy_reg) ? reversed :
		(wide_reg ? crc_reg : {16'h0000, crc_reg[15:0]});

	// ==================================================================
	// Checksum register
	always @* begin
		crc_next = crc_reg;
		if (preset_reg == `PRESET_ZEROS)
			crc_next = 32'h00000000;
		else if (preset_reg == `PRESET_ONES)
			crc_next = 32'hffffffff;
		else if (step_go)
			crc_next = wide_reg ? step_out : {16'h0000, step_out[15:0]};
		else if (wr_pend_reg & ~src_active & idx_reg[3:2] == 2'b01) begin
			for (i = 0; i < 8; i = i + 1) begin
				if (idx_reg[1:0] == `IDX_RESULT0 - 3'h4)
					crc_next[i] = hwdata_i[i];
				if (idx_reg[1:0] == `IDX_RESULT1 - 3'h4)
					crc_next[8 + i] = hwdata_i[i];
				if (idx_reg[1:0] == `IDX_RESULT2 - 3'h4)
					crc_next[16 + i] = hwdata_i[i];
				if (idx_reg[1:0] == `IDX_RESULT3 - 3'h4)
					crc_next[24 + i] = hwdata_i[i];
			end
		end
	end

	always @(posedge sys_clk_i) begin
		if (reset_i) begin
			crc_reg      <= `CRC_RESET;
			source_reg   <= `SRC_DISABLED;
			wide_reg     <= 1'b0;
			busy_reg     <= 1'b0;
			zero_reg     <= 1'b0;
			preset_reg   <= 2'b00;
			irq_mask_reg <= 2'b00;
			wr_pend_reg  <= 1'b0;
			rd_pend_reg  <= 1'b0;
			idx_reg      <= 4'h0;
			rdata_reg    <= 32'h00000000;
		end else if (clk_en_i) begin
			wr_pend_reg <= take & hwrite_i;
			rd_pend_reg <= take & ~hwrite_i;
			if (take)
				idx_reg <= (haddr_i[31:6] == 26'h0) ? a_idx : 4'hf;
			crc_reg    <= crc_next;
			preset_reg <= 2'b00;
			if (done_evt) begin
				busy_reg   <= 1'b0;
				zero_reg   <= (crc_reg == 32'h00000000);
				source_reg <= `SRC_DISABLED;
			end
			if (ctl_write) begin
				// Preset acts one cycle after the upper preset bit is written.
				if (hwdata_i[`CTL_PRESET_HI]) begin
					preset_reg <= hwdata_i[`CTL_PRESET_HI:`CTL_PRESET_LO];
					busy_reg   <= 1'b0;
					source_reg <= `SRC_DISABLED;
				end else begin
					if (~busy_reg)
						wide_reg <= hwdata_i[`CTL_WIDE] |
							(hwdata_i[`CTL_SRC_HI:`CTL_SRC_LO] == `SRC_FLASH);
					// The source stays locked while a calculation runs.
					if (~busy_reg & (hwdata_i[3] == 1'b0) &
						(hwdata_i[`CTL_SRC_HI:`CTL_SRC_LO] != 4'h3)) begin
						source_reg <= hwdata_i[`CTL_SRC_HI:`CTL_SRC_LO];
						busy_reg   <= (hwdata_i[`CTL_SRC_HI:`CTL_SRC_LO] != `SRC_DISABLED);
						if (hwdata_i[`CTL_SRC_HI:`CTL_SRC_LO] != `SRC_DISABLED)
							zero_reg <= 1'b0;
					end
				end
			end
			if (wr_pend_reg & (idx_reg == `IDX_IRQ_MASK))
				irq_mask_reg <= hwdata_i[1:0];
			if (take & ~hwrite_i) begin
				case ((haddr_i[31:6] == 26'h0) ? a_idx : 4'hf)
				{1'b0, `IDX_CONTROL}: rdata_reg <= {24'h0, 2'b00, wide_reg, 1'b0, source_reg};
				{1'b0, `IDX_FLAGS}:   rdata_reg <= {30'h0, zero_reg, busy_reg};
				{1'b0, `IDX_RESULT0}: rdata_reg <= {24'h0, shown[7:0]};
				{1'b0, `IDX_RESULT1}: rdata_reg <= {24'h0, shown[15:8]};
				{1'b0, `IDX_RESULT2}: rdata_reg <= {24'h0, shown[23:16]};
				{1'b0, `IDX_RESULT3}: rdata_reg <= {24'h0, shown[31:24]};
				`IDX_IRQ_STATUS:     rdata_reg <= {30'h0, irq_flags};
				`IDX_IRQ_MASK:       rdata_reg <= {30'h0, irq_mask_reg};
				default:             rdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// ==================================================================
	// Interrupts
	wire status_read;
	assign status_read = rd_pend_reg & (idx_reg == `IDX_IRQ_STATUS);

	crc_irq_bit u_irq_done (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.enable_i  (clk_en_i),
		.set_i     (done_evt),
		.clear_i   (status_read),
		.flag_o    (irq_flags[`IRQ_DONE])
	);

	crc_irq_bit u_irq_zero (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.enable_i  (clk_en_i),
		.set_i     (done_evt & (crc_reg == 32'h00000000)),
		.clear_i   (status_read),
		.flag_o    (irq_flags[`IRQ_ZERO])
	);

	assign irq_o = |(irq_flags & irq_mask_reg);
endmodule // crc_checksum_unit

// file: sim/feed_source_model.sv
/* Model of the DMA or flash-scan source that feeds bytes to the CRC unit.
   Assumes send is called just after a rising clock edge. */
`timescale 1ns/1ps
module feed_source_model (
	input  logic       sys_clk_i,
	output logic       feed_valid_o,
	output logic [7:0] feed_data_o,
	output logic [1:0] feed_channel_o,
	output logic       feed_done_o
);
	initial begin
		feed_valid_o = 1'b0;
		feed_data_o = 8'h00;
		feed_channel_o = 2'h0;
		feed_done_o = 1'b0;
	end
	// ==========
	// Byte stream with a gap, then the completion pulse.
	task automatic send(input int n, input logic [1:0] ch, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_i);
			feed_valid_o <= 1'b1;
			feed_data_o <= 8'h31 + 8'(i);
			feed_channel_o <= ch;
			@(posedge sys_clk_i);
			feed_valid_o <= 1'b0;
			feed_data_o <= ~(8'h31 + 8'(i));
			repeat (gap) @(posedge sys_clk_i);
		end
		@(posedge sys_clk_i);
		feed_done_o <= 1'b1;
		@(posedge sys_clk_i);
		feed_done_o <= 1'b0;
	endtask
endmodule // feed_source_model

// file: sim/crc_unit_assertions.sv
/* Bus and interrupt checks for the CRC checksum unit.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module crc_unit_checker (
	input logic        sys_clk_i,
	input logic        reset_i,
	input logic        clk_en_i,
	input logic        hsel_i,
	input logic [31:0] haddr_i,
	input logic [1:0]  htrans_i,
	input logic        hwrite_i,
	input logic [31:0] hwdata_i,
	input logic        hready_i,
	input logic [31:0] hrdata_o,
	input logic        hreadyout_o,
	input logic        hresp_o,
	input logic        feed_done_i,
	input logic        irq_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// ==========
	// Shadow of the mask and of the flash source.
	wire        tk = hsel_i && hready_i && htrans_i[1] && clk_en_i;
	wire        rd = tk && !hwrite_i;
	logic       wv;
	logic       fl_reg;
	logic [7:0] wa;
	logic [1:0] mask_reg;
	always @(posedge sys_clk_i) begin
		wv <= tk && hwrite_i && !reset_i;
		wa <= haddr_i[7:0];
		if (reset_i) begin
			mask_reg <= 2'h0;
			fl_reg <= 1'b0;
		end else begin
			if (wv && wa == 8'h24) mask_reg <= hwdata_i[1:0];
			if (feed_done_i || (wv && wa == 8'h00)) fl_reg <= !feed_done_i && hwdata_i[7:0] == 8'h02;
		end
	end
	// ==========
	// Properties.
	bus_ready_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus stalled or not okay");
	reset_clear_a: assert property ($fell(reset_i) |-> hrdata_o == 32'h0 && !irq_o)
		else $error("outputs not clear after reset");
	upper_zero_a: assert property (rd |=> hrdata_o[31:8] == 24'h0)
		else $error("read upper bits set");
	unmapped_zero_a: assert property (rd && (haddr_i >= 32'h40 || haddr_i == 32'h8) |=> !hrdata_o)
		else $error("unmapped read not zero");
	preset_read_a: assert property (rd && haddr_i == 32'h0 |=> hrdata_o[7:6] == 2'h0)
		else $error("preset field reads nonzero");
	flash_zero_a: assert property (rd && fl_reg && !feed_done_i && haddr_i[31:4] == 28'h1 |=> !hrdata_o)
		else $error("result readable during flash scan");
	irq_mask_a: assert property (irq_o |-> mask_reg != 2'h0)
		else $error("interrupt with all bits masked");
	status_clear_a: assert property (rd && haddr_i == 32'h20 && !feed_done_i ##1 !feed_done_i ##1 !feed_done_i |-> !irq_o)
		else $error("interrupt stays after status read");
endmodule // crc_unit_checker
bind crc_checksum_unit crc_unit_checker chk_i (.*);

// file: sim/testbench.sv
/* Self-checking bench for the CRC checksum unit: register rows, then CRC runs over the bus
   and from the feed model. Assumes design, model and checker are compiled first. */
`timescale 1ns/1ps
`include "crc_unit_defs.vh"
module testbench;
	logic        sys_clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, hsel_i = 1'b1, hwrite_i = 1'b0;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, v, s;
	logic [1:0]  htrans_i = 2'h0;
	logic [2:0]  hsize_i = 3'h2;
	wire  [31:0] hrdata_o;
	wire  [7:0]  feed_data_i;
	wire  [1:0]  feed_channel_i;
	wire         hready_i, hreadyout_o, hresp_o, feed_valid_i, feed_done_i, irq_o;
	int          n_errors = 0, tests_run = 0, cycles = 0;
	logic [40:0] rows[22] = '{{1'b0,8'h00,32'h0}, {1'b0,8'h04,32'h0}, {1'b0,8'h08,32'h0},
		{1'b0,8'h10,32'h0}, {1'b0,8'h14,32'h0}, {1'b0,8'h18,32'h0}, {1'b0,8'h1c,32'h0},
		{1'b0,8'h20,32'h0}, {1'b0,8'h24,32'h0}, {1'b0,8'h40,32'h0}, {1'b1,8'h10,32'ha5},
		{1'b1,8'h14,32'h3c}, {1'b0,8'h10,32'ha5}, {1'b0,8'h14,32'h3c}, {1'b1,8'h24,32'h3},
		{1'b0,8'h24,32'h3}, {1'b1,8'h24,32'h0}, {1'b1,8'h00,32'hc0}, {1'b0,8'h00,32'h0},
		{1'b0,8'h10,32'hff}, {1'b0,8'h14,32'hff}, {1'b0,8'h18,32'h0}};
	assign hready_i = hreadyout_o;
	always #10 sys_clk_i = ~sys_clk_i;
	crc_checksum_unit DUT (.*);
	feed_source_model src (.sys_clk_i, .feed_valid_o(feed_valid_i), .feed_data_o(feed_data_i),
		.feed_channel_o(feed_channel_i), .feed_done_o(feed_done_i));
	// ==========
	// Reference CRC, bus tasks and reporting.
	function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] b, input logic w);
		for (int i = 7; i >= 0; i--)
			if (w) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? `POLY_WIDE : 32'h0);
			else c = {16'h0, c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? {16'h0, `POLY_NARROW} : 32'h0);
		return c;
	endfunction
	function automatic logic [31:0] rv(input logic [31:0] x);
		for (int i = 0; i < 32; i++) rv[i] = ~x[31 - i];
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		htrans_i <= 2'h2;
		haddr_i <= {24'h0, a};
		hwrite_i <= w;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask
	task automatic rres(output logic [31:0] r);
		logic [31:0] t;
		for (int k = 0; k < 4; k++) begin
			xfer(1'b0, 8'h10 + 8'(4 * k), 32'h0, t);
			r[8 * k +: 8] = t[7:0];
		end
	endtask
	task automatic feed_bus(input int n, input logic w);
		htrans_i <= 2'h2;
		haddr_i <= 32'hc;
		hwrite_i <= 1'b1;
		for (int i = 0; i <= n; i++) begin
			do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
			hwdata_i <= 32'h31 + i;
			if (i >= n - 1) htrans_i <= 2'h0;
			if (i < n) s = step(s, 8'h31 + 8'(i), w);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			end_of_test();
		end
	end
	// ==========
	// Main sequence.
	initial begin
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		foreach (rows[k]) begin
			xfer(rows[k][40], rows[k][39:32], rows[k][31:0], v);
			if (!rows[k][40]) chk("register", rows[k][31:0], v);
		end
		s = 32'hffffffff;
		xfer(1'b1, 8'h00, 32'h01, v);
		xfer(1'b1, 8'h10, 32'h00, v);
		feed_bus(9, 1'b0);
		rres(v);
		chk("narrow", {16'h0, s[15:0]}, v);
		xfer(1'b1, 8'h04, 32'h01, v);
		xfer(1'b0, 8'h04, 32'h0, v);
		chk("flags", 32'h0, v);
		chk("irq masked", 32'h0, {31'h0, irq_o});
		xfer(1'b0, 8'h20, 32'h0, v);
		xfer(1'b1, 8'h00, 32'h80, v);
		xfer(1'b1, 8'h00, 32'h21, v);
		s = 32'h0;
		feed_bus(9, 1'b1);
		xfer(1'b1, 8'h04, 32'h01, v);
		rres(v);
		chk("wide", rv(s), v);
		xfer(1'b0, 8'h20, 32'h0, v);
		xfer(1'b1, 8'h24, 32'h1, v);
		xfer(1'b1, 8'h00, 32'h80, v);
		xfer(1'b1, 8'h00, 32'h07, v);
		src.send(3, 2'h3, 0);
		s = 32'h0;
		for (int i = 0; i < 3; i++) s = step(s, 8'h31 + 8'(i), 1'b0);
		rres(v);
		chk("dma", {16'h0, s[15:0]}, v);
		chk("irq set", 32'h1, {31'h0, irq_o});
		xfer(1'b0, 8'h20, 32'h0, v);
		chk("status", 32'h1, v);
		@(posedge sys_clk_i);
		chk("irq clear", 32'h0, {31'h0, irq_o});
		xfer(1'b1, 8'h00, 32'h80, v);
		xfer(1'b1, 8'h00, 32'h02, v);
		fork
			src.send(4, 2'h0, 3);
			begin
				rres(v);
				chk("flash busy", 32'h0, v);
			end
		join
		s = 32'h0;
		for (int i = 0; i < 4; i++) s = step(s, 8'h31 + 8'(i), 1'b1);
		rres(v);
		chk("flash", rv(s), v);
		xfer(1'b1, 8'h24, 32'h3, v);
		xfer(1'b1, 8'h00, 32'h80, v);
		xfer(1'b1, 8'h00, 32'h01, v);
		xfer(1'b1, 8'h04, 32'h01, v);
		xfer(1'b0, 8'h04, 32'h0, v);
		chk("zero flag", 32'h2, v);
		chk("irq zero", 32'h1, {31'h0, irq_o});
		xfer(1'b0, 8'h20, 32'h0, v);
		chk("status zero", 32'h3, v);
		xfer(1'b1, 8'h00, 32'h05, v);
		src.send(2, 2'h2, 0);
		xfer(1'b1, 8'h00, 32'h01, v);
		clk_en_i <= 1'b0;
		xfer(1'b1, 8'h0c, 32'h55, v);
		clk_en_i <= 1'b1;
		xfer(1'b1, 8'h04, 32'h01, v);
		rres(v);
		chk("frozen and foreign bytes", 32'h0, v);
		reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rres(v);
		chk("reset", 32'h0, v);
		end_of_test();
	end
endmodule // testbench
